// >>> src/boot_cfg_pkg.sv
// Purpose: constants for the boot configuration and status register
// Assumes: 25 MHz system clock, longword reads from processor I/O space
// Notes:   one register replicated over 32 longwords
// How it works
// - Bit 31 shows the remote boot jumper: 0 allows remote boots, 1 ignores them.
// - Bit 30 reads 0 for a sound console cable and 1 for faulty or reversed.
// - Cable test drives a signal out on one conductor and samples it back on another.
// - Bits 26:24 give the external storage bus node number.
// - Bits 18:16 give the internal storage bus node number.
// - Bits 15:8 give checksum byte 0 at offset 18 and byte 1 at offset 1C.
// - ROM positions after the first eight bytes hold test data.
// - Bit 7 shows the break enable switch and ignores writes.
// - A console break halts the processor only while bit 7 is set.
// - The register repeats over 32 longwords with only bits 15:8 varying.
package boot_cfg_pkg;
    localparam int          NUM_LONGWORDS   = 32;
    localparam int          IDX_W           = 5;
    localparam int          ADDR_LSB        = 2;
    localparam int          BIT_NET_INHIBIT = 31;
    localparam int          BIT_CABLE_FAULT = 30;
    localparam int          EXT_NODE_LSB    = 24;
    localparam int          INT_NODE_LSB    = 16;
    localparam int          LAN_BYTE_LSB    = 8;
    localparam int          BIT_HALT_ENB    = 7;
    localparam logic [31:0] UNDEF_FILL      = 32'h0000_0000;
    localparam logic [31:0] RDATA_RESET     = 32'h0000_0000;
    localparam logic [4:0]  CKSUM0_IDX      = 5'h06;
    localparam logic [4:0]  CKSUM1_IDX      = 5'h07;
    localparam logic [4:0]  TEST_FIRST_IDX  = 5'h08;
    localparam int          CABLE_TEST_NS   = 2000;
    localparam int          CLK_NS          = 40;
    localparam int          CABLE_TEST_CYC  =
        (CABLE_TEST_NS + CLK_NS - 1) / CLK_NS;
endpackage

// >>> src/lan_addr_rom.sv
// Purpose: station address ROM, 32 bytes, registered read data
// Assumes: contents fixed at elaboration
// Notes:   bytes 8 and up hold test pattern data
`timescale 1ns/10ps
module lan_addr_rom
    import boot_cfg_pkg::*;
#(
    parameter logic [47:0] STATION_ADDR = 48'h0000_0000_0000
) (
    input  wire logic             clk_sys_i,
    input  wire logic             rst_n_i,
    input  wire logic [IDX_W-1:0] idx_i,
    output logic      [7:0]       byte_o
);
    logic [7:0] byte_d;
    logic [15:0] cksum;

    // Simple additive checksum over the six address bytes
    always_comb begin
        cksum = 16'h0000;
        for (int i = 0; i < 6; i++) begin
            cksum = cksum + {8'h00, STATION_ADDR[i*8 +: 8]};
        end
    end

    always_comb begin
        if (idx_i < CKSUM0_IDX) begin
            byte_d = STATION_ADDR[idx_i*8 +: 8];
        end else if (idx_i == CKSUM0_IDX) begin
            byte_d = cksum[7:0];
        end else if (idx_i == CKSUM1_IDX) begin
            byte_d = cksum[15:8];
        end else begin
            // Alternating pattern marks the test area
            byte_d = {3'h5, idx_i} ^ 8'hAA;
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            byte_o <= 8'h00;
        end else begin
            byte_o <= byte_d;
        end
    end
endmodule

// >>> src/boot_config_status.sv
// Purpose: read-only boot configuration and status register
// Assumes: read strobe and address synchronous to clk_sys_i
// Notes:   read data valid two cycles after the strobe; writes ignored
`timescale 1ns/10ps
module boot_config_status
    import boot_cfg_pkg::*;
#(
    parameter logic [47:0] STATION_ADDR = 48'h0000_0000_0000
) (
    input  wire logic        clk_sys_i,
    input  wire logic        nrst_i,
    input  wire logic        rd_i,
    input  wire logic        wr_i,
    input  wire logic [6:0]  addr_i,
    output logic      [31:0] rdata_o,
    output logic             rvalid_o,
    input  wire logic        net_boot_inhibit_i,
    input  wire logic        halt_on_break_enable_i,
    input  wire logic [2:0]  external_storage_node_id_i,
    input  wire logic [2:0]  internal_storage_node_id_i,
    output logic             cable_test_o,
    input  wire logic        cable_return_i,
    input  wire logic        break_detect_i,
    output logic             halt_req_o
);
    localparam int SYNC_W = 8;
    localparam int RET_W  = 2;

    // Synchroniser word order: inhibit, halt enable, external, internal
    logic [1:0]        rst_sync_q;
    logic [1:0]        rst_sync_d;
    logic              rst_n;
    logic [SYNC_W-1:0] sync_in;
    logic [SYNC_W-1:0] sync1_q;
    logic [SYNC_W-1:0] sync1_d;
    logic [SYNC_W-1:0] sync2_q;
    logic [SYNC_W-1:0] sync2_d;
    logic [RET_W-1:0]  ret_in;
    logic [RET_W-1:0]  ret1_q;
    logic [RET_W-1:0]  ret1_d;
    logic [RET_W-1:0]  ret2_q;
    logic [RET_W-1:0]  ret2_d;
    logic [15:0]       tcnt_q;
    logic [15:0]       tcnt_d;
    logic              drive_q;
    logic              drive_d;
    logic              fault_q;
    logic              fault_d;
    logic              bad_q;
    logic              bad_d;
    logic              mismatch;
    logic              period_end;
    logic [IDX_W-1:0]  rom_idx;
    logic [7:0]        lan_addr;
    logic              take_rd;
    logic              rd_q;
    logic              rd_d;
    logic [31:0]       rdata_d;
    logic [31:0]       rdata_next;
    logic              rvalid_d;
    logic              halt_d;

    // Refuse package values the fixed-width logic cannot serve
    if (NUM_LONGWORDS != (1 << IDX_W)) begin : g_chk_idx
        $error("longword count does not match index width");
    end
    if (ADDR_LSB + IDX_W > 7) begin : g_chk_addr
        $error("longword index does not fit the address port");
    end
    if (CABLE_TEST_CYC < 8 || CABLE_TEST_CYC > 65535) begin : g_chk_cbl
        $error("cable test period out of range");
    end
    if (TEST_FIRST_IDX != CKSUM1_IDX + 5'h01) begin : g_chk_rom
        $error("test area must follow the checksum bytes");
    end
    if (BIT_HALT_ENB >= LAN_BYTE_LSB) begin : g_chk_fields
        $error("halt enable bit overlaps the address byte");
    end

    // Release is synchronised; assertion stays asynchronous
    always_comb begin
        rst_sync_d = {rst_sync_q[0], 1'b1};
    end

    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rst_sync_q <= 2'h0;
        end else begin
            rst_sync_q <= rst_sync_d;
        end
    end
    assign rst_n = rst_sync_q[1];

    assign sync_in = {net_boot_inhibit_i, halt_on_break_enable_i,
                      external_storage_node_id_i,
                      internal_storage_node_id_i};
    assign ret_in  = {cable_return_i, break_detect_i};

    // Two stages keep a slow switch edge from reaching a read
    always_comb begin
        sync1_d = sync_in;
        sync2_d = sync1_q;
        ret1_d  = ret_in;
        ret2_d  = ret1_q;
    end

    always_ff @(posedge clk_sys_i or negedge rst_n) begin
        if (!rst_n) begin
            sync1_q <= '0;
            sync2_q <= '0;
            ret1_q  <= '0;
            ret2_q  <= '0;
        end else begin
            sync1_q <= sync1_d;
            sync2_q <= sync2_d;
            ret1_q  <= ret1_d;
            ret2_q  <= ret2_d;
        end
    end

    // Return lags the drive by three edges, so early cycles are skipped
    assign mismatch   = ret2_q[1] != drive_q;
    assign period_end = tcnt_q == 16'(CABLE_TEST_CYC - 1);

    always_comb begin
        tcnt_d  = tcnt_q + 16'h0001;
        drive_d = drive_q;
        fault_d = fault_q;
        bad_d   = bad_q;
        if (period_end) begin
            tcnt_d  = 16'h0000;
            fault_d = bad_q | mismatch;
            bad_d   = 1'b0;
            drive_d = ~drive_q;
        end else if (tcnt_q > 16'h0003 && mismatch) begin
            bad_d = 1'b1;
        end
    end

    // Fault reads set until the first full period has been judged
    always_ff @(posedge clk_sys_i or negedge rst_n) begin
        if (!rst_n) begin
            tcnt_q  <= 16'h0000;
            drive_q <= 1'b0;
            fault_q <= 1'b1;
            bad_q   <= 1'b0;
        end else begin
            tcnt_q  <= tcnt_d;
            drive_q <= drive_d;
            fault_q <= fault_d;
            bad_q   <= bad_d;
        end
    end
    assign cable_test_o = drive_q;

    // Bits 6:2 pick the longword; byte lanes are not decoded
    assign rom_idx = addr_i[ADDR_LSB +: IDX_W];

    lan_addr_rom #(
        .STATION_ADDR (STATION_ADDR)
    ) u_rom (
        .clk_sys_i (clk_sys_i),
        .rst_n_i   (rst_n),
        .idx_i     (rom_idx),
        .byte_o    (lan_addr)
    );

    // A write, or a read flagged as a write, is never answered
    assign take_rd = rd_i & ~wr_i;

    // Undefined bits are fixed so a careless read is repeatable
    always_comb begin
        rdata_d = UNDEF_FILL;
        rdata_d[BIT_NET_INHIBIT] = sync2_q[7];
        rdata_d[BIT_CABLE_FAULT] = fault_q;
        rdata_d[EXT_NODE_LSB +: 3] = sync2_q[5:3];
        rdata_d[INT_NODE_LSB +: 3] = sync2_q[2:0];
        rdata_d[LAN_BYTE_LSB +: 8] = lan_addr;
        rdata_d[BIT_HALT_ENB] = sync2_q[6];
    end

    // ROM data lags one cycle, so answer two cycles after the strobe
    always_comb begin
        rd_d       = take_rd;
        rvalid_d   = rd_q;
        rdata_next = rd_q ? rdata_d : rdata_o;
        halt_d     = ret2_q[0] & sync2_q[6];
    end

    always_ff @(posedge clk_sys_i or negedge rst_n) begin
        if (!rst_n) begin
            rd_q     <= 1'b0;
            rvalid_o <= 1'b0;
        end else begin
            rd_q     <= rd_d;
            rvalid_o <= rvalid_d;
        end
    end

    // Word holds until the next answer, so a late sample still sees it
    always_ff @(posedge clk_sys_i or negedge rst_n) begin
        if (!rst_n) begin
            rdata_o <= RDATA_RESET;
        end else begin
            rdata_o <= rdata_next;
        end
    end

    // Halt is a level: it follows break only while the switch enables it
    always_ff @(posedge clk_sys_i or negedge rst_n) begin
        if (!rst_n) begin
            halt_req_o <= 1'b0;
        end else begin
            halt_req_o <= halt_d;
        end
    end
endmodule

// >>> verif/bcs_chk_assertions.sv
// Purpose: port assertions for the boot configuration register
// Assumes: static inputs held for six cycles before a read is taken
// Notes:   bound into every boot_config_status instance
`timescale 1ns/10ps
module bcs_chk (
    input wire logic        clk_sys_i,
    input wire logic        nrst_i,
    input wire logic        rd_i,
    input wire logic        wr_i,
    input wire logic [31:0] rdata_o,
    input wire logic        rvalid_o,
    input wire logic        net_boot_inhibit_i,
    input wire logic        halt_on_break_enable_i,
    input wire logic [2:0]  external_storage_node_id_i,
    input wire logic [2:0]  internal_storage_node_id_i,
    input wire logic        cable_test_o,
    input wire logic        break_detect_i,
    input wire logic        halt_req_o
);
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!nrst_i);
    // Field checks assume no input change inside the sync window
    property p_rd; rd_i && !wr_i |-> ##2 rvalid_o; endproperty
    a_rd: assert property (p_rd) else $error("read not answered");
    property p_wr; wr_i |-> ##2 !rvalid_o; endproperty
    a_wr: assert property (p_wr) else $error("write answered");
    property p_only; rvalid_o |-> $past(rd_i && !wr_i, 2); endproperty
    a_only: assert property (p_only) else $error("stray valid");
    property p_inh;
        rvalid_o |-> rdata_o[31] == $past(net_boot_inhibit_i, 6);
    endproperty
    a_inh: assert property (p_inh) else $error("bit 31 wrong");
    property p_ext;
        rvalid_o |-> rdata_o[26:24] == $past(external_storage_node_id_i, 6);
    endproperty
    a_ext: assert property (p_ext) else $error("ext node wrong");
    property p_int;
        rvalid_o |-> rdata_o[18:16] == $past(internal_storage_node_id_i, 6);
    endproperty
    a_int: assert property (p_int) else $error("int node wrong");
    property p_hen;
        rvalid_o |-> rdata_o[7] == $past(halt_on_break_enable_i, 6);
    endproperty
    a_hen: assert property (p_hen) else $error("bit 7 wrong");
    property p_halt;
        $past(nrst_i, 8) |-> halt_req_o ==
            ($past(break_detect_i, 3) && $past(halt_on_break_enable_i, 3));
    endproperty
    a_halt: assert property (p_halt) else $error("halt wrong");
    property p_cbl; $rose(cable_test_o) |-> ##50 $fell(cable_test_o); endproperty
    a_cbl: assert property (p_cbl) else $error("cable drive period");
    c_bad: cover property (rvalid_o && rdata_o[30]);
    c_ok: cover property (rvalid_o && !rdata_o[30]);
    c_halt: cover property (halt_req_o);
endmodule
bind boot_config_status bcs_chk u_chk (.*);

// >>> verif/tb_top.sv
// Purpose: self-checking bench for the boot configuration register
// Assumes: one read every second cycle, inputs static during reads
// Notes:   driver queues expected words, monitor pops them
`timescale 1ns/10ps
module tb_top;
    localparam logic [47:0] SA = 48'h5E4D_3C2B_1A09;
    logic        clk_sys_i = 1'b0, nrst_i = 1'b0, rd_i = 1'b0, wr_i = 1'b0;
    logic        net_boot_inhibit_i = 1'b0, halt_on_break_enable_i = 1'b0;
    logic        cable_return_i = 1'b0, break_detect_i = 1'b0, bad = 1'b0;
    logic        rvalid_o, cable_test_o, halt_req_o;
    logic [2:0]  external_storage_node_id_i = 3'h0;
    logic [2:0]  internal_storage_node_id_i = 3'h0;
    logic [6:0]  addr_i = 7'h00;
    logic [31:0] rdata_o, e, q[$];
    int          n_mismatch = 0, checks = 0, up = 0;
    logic [2:0]  hp = 3'h0;
    boot_config_status #(.STATION_ADDR(SA)) dut (.*);
    initial forever #20 clk_sys_i = ~clk_sys_i;
    always @(posedge clk_sys_i) begin
        cable_return_i <= bad ? ~cable_test_o : cable_test_o;
        break_detect_i <= 1'($urandom);
        hp <= {hp[1:0], break_detect_i & halt_on_break_enable_i};
        up <= nrst_i ? up + 1 : 0;
    end
    task automatic cmp_halt(logic ex, logic g);
        checks++;
        if (g !== ex) begin
            n_mismatch++;
            $display("mismatch halt_req_o expected %b seen %b", ex, g);
        end
    endtask
    task automatic cmp(string nm, logic [31:0] ex, logic [31:0] g);
        checks++;
        if (g !== ex) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", nm, ex, g);
        end
    endtask
    function automatic logic [7:0] rom(int i);
        logic [15:0] s;
        s = 16'h0000;
        for (int k = 0; k < 6; k++) s += 16'(SA[8*k +: 8]);
        if (i < 6) return SA[8*i +: 8];
        if (i < 8) return (i == 6) ? s[7:0] : s[15:8];
        return {3'b101, 5'(i)} ^ 8'hAA;
    endfunction
    task automatic rd(int i, logic w);
        rd_i <= 1'b1;
        wr_i <= w;
        addr_i <= 7'(i * 4);
        if (!w) q.push_back({net_boot_inhibit_i, bad, 3'h0,
            external_storage_node_id_i, 5'h00, internal_storage_node_id_i,
            rom(i), halt_on_break_enable_i, 7'h00});
        @(posedge clk_sys_i);
        rd_i <= 1'b0;
        wr_i <= 1'b0;
        @(posedge clk_sys_i);
    endtask
    always @(negedge clk_sys_i) begin
        if (rvalid_o === 1'b1) begin
            e = (q.size() != 0) ? q.pop_front() : 'x;
            cmp("rdata_o", e, rdata_o);
        end
        if (up > 8) cmp_halt(hp[2], halt_req_o);
    end
    task automatic conclude();
        if (q.size() != 0) n_mismatch++;
        if (n_mismatch == 0 && checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    initial begin
        repeat (3000) @(posedge clk_sys_i);
        n_mismatch++;
        conclude();
    end
    initial begin
        void'($urandom(39000));
        repeat (10) @(posedge clk_sys_i);
        nrst_i <= 1'b1;
        for (int r = 0; r < 4; r++) begin
            {net_boot_inhibit_i, halt_on_break_enable_i,
             external_storage_node_id_i,
             internal_storage_node_id_i} <= 8'($urandom);
            bad <= r[0];
            repeat (130) @(posedge clk_sys_i);
            for (int i = 0; i < 32; i++) rd(i, i % 5 == 4);
        end
        repeat (4) @(posedge clk_sys_i);
        conclude();
    end
endmodule
